// [csd_framer.v]
// Status block framer, byte-order stage and diagnostic registers.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "csd_regs.vh"
module csd_framer (
    // APB clock, reset and slave port.
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Diagnostic inputs from the local bus side.
    input wire new_diag_msg,
    input wire [15:0] lbus_diag_status,
    input wire [15:0] mod_err_code,
    input wire [15:0] mod_err_pos,
    // Application-layer error events, one-cycle pulses.
    input wire [`CSD_EV_W-1:0] al_err_evt,
    // Application-layer status outputs.
    output reg al_err,
    output reg [15:0] al_code,
    // Non-volatile byte-order setting.
    input wire [`CSD_SWAP_W-1:0] nv_swap,
    input wire nv_swap_valid,
    output reg nv_we,
    output reg [`CSD_SWAP_W-1:0] nv_wdata,
    // Module input data stream.
    input wire cyc_start,
    input wire mod_valid,
    input wire [63:0] mod_data,
    input wire [1:0] mod_width,
    input wire mod_last,
    output reg mod_ready,
    // Input process image byte stream.
    output reg pi_valid,
    output reg [7:0] pi_data,
    output reg pi_first,
    output reg pi_last,
    // Emergency error events and messages.
    input wire lbus_err_evt,
    input wire [15:0] lbus_err_slot,
    input wire [15:0] lbus_err_code,
    input wire io_err_evt,
    input wire [15:0] io_err_code,
    input wire [15:0] io_err_slot,
    input wire [7:0] io_err_loc,
    input wire [7:0] io_err_prio,
    output wire emcy_valid,
    output wire [63:0] emcy_msg
);
    localparam ST_IDLE = 2'h0;
    localparam ST_STAT = 2'h1;
    localparam ST_DATA = 2'h2;

    // Highest-priority pending event picks the code.
    function [15:0] al_code_of;
        input [`CSD_EV_W-1:0] ev;
        begin
            if (ev[`CSD_EV_WDOG])
                al_code_of = `CSD_AL_WDOG;
            else if (ev[`CSD_EV_MBX_CFG])
                al_code_of = `CSD_AL_MBX_CFG;
            else if (ev[`CSD_EV_OUT_CFG])
                al_code_of = `CSD_AL_OUT_CFG;
            else if (ev[`CSD_EV_IN_CFG])
                al_code_of = `CSD_AL_IN_CFG;
            else if (ev[`CSD_EV_SYNC])
                al_code_of = `CSD_AL_SYNC;
            else if (ev[`CSD_EV_NO_STATE])
                al_code_of = `CSD_AL_NO_STATE;
            else if (ev[`CSD_EV_BAD_CHANGE])
                al_code_of = `CSD_AL_BAD_CHANGE;
            else
                al_code_of = `CSD_AL_OK;
        end
    endfunction

    function [3:0] nbytes;
        input [1:0] w;
        begin
            case (w)
                `CSD_WID_16: nbytes = 4'h2;
                `CSD_WID_32: nbytes = 4'h4;
                `CSD_WID_64: nbytes = 4'h8;
                default: nbytes = 4'h1;
            endcase
        end
    endfunction

    // Registers show a 16-bit value in the low half; the rest reads zero.
    function [31:0] ext16;
        input [15:0] v;
        begin
            ext16 = {16'h0000, v};
        end
    endfunction

    reg [`CSD_SWAP_W-1:0] swap;
    reg nv_loaded;
    reg [63:0] stat_blk;
    reg [1:0] state;
    reg [3:0] idx;
    reg [63:0] item;
    reg [3:0] cnt;
    reg item_last;
    reg [1:0] next_state;
    reg [3:0] next_cnt;
    wire [63:0] item_bytes;
    wire setup;
    wire wr;
    wire take;
    wire al_clr;
    wire [15:0] word0;
    wire [15:0] word1;
    wire [15:0] word2;
    wire [15:0] word3;

    assign setup = psel && !penable;
    assign wr = setup && pwrite;
    assign take = mod_valid && mod_ready;
    assign al_clr = wr && (paddr == `CSD_ADDR_AL_STAT) &&
        pwdata[`CSD_AL_ERR_BIT];

    // One snapshot feeds both the image and the diagnostic registers.
    assign word0 = stat_blk[15:0];
    assign word1 = stat_blk[31:16];
    assign word2 = stat_blk[47:32];
    assign word3 = stat_blk[63:48];

    csd_swap u_swap (
        .item(mod_data),
        .width(mod_width),
        .swap(swap),
        .bytes(item_bytes)
    );

    csd_emcy u_emcy (
        .pclk(pclk),
        .presetn(presetn),
        .bus_evt(lbus_err_evt),
        .bus_slot(lbus_err_slot),
        .bus_code(lbus_err_code),
        .io_evt(io_err_evt),
        .io_code(io_err_code),
        .io_slot(io_err_slot),
        .io_loc(io_err_loc),
        .io_prio(io_err_prio),
        .emcy_valid(emcy_valid),
        .emcy_msg(emcy_msg)
    );

    // APB slave: the write takes effect in the setup cycle and the answer
    // is ready in the first access cycle, so no wait state is ever added.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= 1'b0;
            if (setup) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    `CSD_ADDR_CTRL:
                        prdata <= {29'h0000_0000, swap};
                    `CSD_ADDR_AL_STAT:
                        prdata[`CSD_AL_ERR_BIT] <= al_err;
                    `CSD_ADDR_AL_CODE:
                        prdata <= ext16(al_code);
                    `CSD_ADDR_DIAG_BUS:
                        prdata <= ext16(word1);
                    `CSD_ADDR_DIAG_CODE:
                        prdata <= ext16(word2);
                    `CSD_ADDR_DIAG_POS:
                        prdata <= ext16(word3);
                    `CSD_ADDR_STAT0:
                        prdata <= ext16(word0);
                    default:
                        pslverr <= 1'b1;
                endcase
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // The stored setting is taken once after reset, when storage reports
    // it valid, unless a CTRL write came first; until then the little-endian default applies.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swap <= `CSD_SWAP_RESET;
            nv_loaded <= 1'b0;
            nv_we <= 1'b0;
            nv_wdata <= `CSD_SWAP_RESET;
        end else begin
            nv_we <= 1'b0;
            if (wr && paddr == `CSD_ADDR_CTRL) begin
                swap <= pwdata[`CSD_SWAP_W-1:0];
                nv_we <= 1'b1;
                nv_wdata <= pwdata[`CSD_SWAP_W-1:0];
                nv_loaded <= 1'b1;
            end else if (!nv_loaded && nv_swap_valid) begin
                swap <= nv_swap;
                nv_loaded <= 1'b1;
            end
        end
    end

    // Application-layer error: a new event wins over a clear written in
    // the same cycle, so an event is not lost to a coincident clear.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            al_err <= 1'b0;
            al_code <= `CSD_AL_OK;
        end else if (|al_err_evt) begin
            al_err <= 1'b1;
            al_code <= al_code_of(al_err_evt);
        end else if (al_clr) begin
            al_err <= 1'b0;
            al_code <= `CSD_AL_OK;
        end
    end

    // The status block is frozen at cycle start so that the image and the
    // diagnostic registers always show one consistent snapshot.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_blk <= 64'h0000_0000_0000_0000;
        end else if (cyc_start && state == ST_IDLE) begin
            stat_blk <= {mod_err_pos,
                mod_err_code,
                lbus_diag_status,
                8'h00, 7'h00,
                new_diag_msg};
        end
    end

    always @* begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_IDLE: begin
                if (cyc_start)
                    next_state = ST_STAT;
            end
            ST_STAT: begin
                if (idx == `CSD_STAT_BYTES - 4'h1)
                    next_state = ST_DATA;
            end
            ST_DATA: begin
                if (take)
                    next_cnt = nbytes(mod_width);
                else if (cnt != 4'h0) begin
                    next_cnt = cnt - 4'h1;
                    if (cnt == 4'h1 && item_last)
                        next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt = 4'h0;
            end
        endcase
    end

    // Image stream: eight status bytes, then module bytes in the chosen
    // order. A fresh item is asked for only once the last one is sent.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            idx <= 4'h0;
            item <= 64'h0000_0000_0000_0000;
            cnt <= 4'h0;
            item_last <= 1'b0;
            mod_ready <= 1'b0;
            pi_valid <= 1'b0;
            pi_data <= 8'h00;
            pi_first <= 1'b0;
            pi_last <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            mod_ready <= (next_state == ST_DATA) && (next_cnt == 4'h0);
            pi_valid <= 1'b0;
            pi_first <= 1'b0;
            pi_last <= 1'b0;
            case (state)
                ST_IDLE: begin
                    idx <= 4'h0;
                end
                ST_STAT: begin
                    pi_valid <= 1'b1;
                    pi_first <= (idx == 4'h0);
                    pi_data <= stat_blk[idx[2:0]*8 +: 8];
                    idx <= idx + 4'h1;
                end
                ST_DATA: begin
                    if (take) begin
                        item <= item_bytes;
                        item_last <= mod_last;
                    end else if (cnt != 4'h0) begin
                        pi_valid <= 1'b1;
                        pi_data <= item[7:0];
                        pi_last <= (cnt == 4'h1) && item_last;
                        item <= {8'h00, item[63:8]};
                    end
                end
                default: begin
                    idx <= 4'h0;
                end
            endcase
        end
    end
endmodule

// [csd_regs.vh]
// Register offsets, field positions, reset values and codes of the framer.
`ifndef CSD_REGS_VH
`define CSD_REGS_VH
// Register byte addresses on the APB bus.
`define CSD_ADDR_CTRL 8'h00
`define CSD_ADDR_AL_STAT 8'h04
`define CSD_ADDR_AL_CODE 8'h08
`define CSD_ADDR_DIAG_BUS 8'h0C
`define CSD_ADDR_DIAG_CODE 8'h10
`define CSD_ADDR_DIAG_POS 8'h14
`define CSD_ADDR_STAT0 8'h18
// Byte-order setting: one bit per multi-byte width (16, 32, 64), high selects little endian.
`define CSD_SWAP_W 3
`define CSD_SWAP_RESET 3'h7
`define CSD_SWAP_WORD 0
`define CSD_SWAP_DWORD 1
`define CSD_SWAP_LWORD 2
// Application-layer status error bit and its clear bit.
`define CSD_AL_ERR_BIT 4
// Application-layer status codes.
`define CSD_AL_OK 16'h0000
`define CSD_AL_BAD_CHANGE 16'h0011
`define CSD_AL_NO_STATE 16'h0012
`define CSD_AL_MBX_CFG 16'h0016
`define CSD_AL_WDOG 16'h001B
`define CSD_AL_OUT_CFG 16'h001D
`define CSD_AL_IN_CFG 16'h001E
`define CSD_AL_SYNC 16'h0028
// Error event input positions.
`define CSD_EV_BAD_CHANGE 0
`define CSD_EV_NO_STATE 1
`define CSD_EV_MBX_CFG 2
`define CSD_EV_WDOG 3
`define CSD_EV_OUT_CFG 4
`define CSD_EV_IN_CFG 5
`define CSD_EV_SYNC 6
`define CSD_EV_W 7
// Status block and item widths.
`define CSD_STAT_BYTES 4'h8
`define CSD_WID_8 2'h0
`define CSD_WID_16 2'h1
`define CSD_WID_32 2'h2
`define CSD_WID_64 2'h3
// Emergency message fields.
`define CSD_EMCY_BUS_CODE 16'h1000
`define CSD_EMCY_ERR_REG 8'h80
`endif

// [csd_swap.v]
// Byte-order selection for one 8, 16, 32 or 64-bit module data item.
`timescale 1ns/1ps
`include "csd_regs.vh"
module csd_swap (
    // Item in, value right aligned.
    input wire [63:0] item,
    input wire [1:0] width,
    // Byte-order setting.
    input wire [`CSD_SWAP_W-1:0] swap,
    // Bytes out, first byte to send in bits 7:0.
    output reg [63:0] bytes
);
    integer i;
    reg little;
    reg [3:0] n;
    always @* begin
        little = 1'b1;
        n = 4'h1;
        case (width)
            `CSD_WID_16: begin
                little = swap[`CSD_SWAP_WORD];
                n = 4'h2;
            end
            `CSD_WID_32: begin
                little = swap[`CSD_SWAP_DWORD];
                n = 4'h4;
            end
            `CSD_WID_64: begin
                little = swap[`CSD_SWAP_LWORD];
                n = 4'h8;
            end
            default: begin
                little = 1'b1;
                n = 4'h1;
            end
        endcase
        bytes = item;
        // Big endian sends the most significant byte of the item first.
        if (!little) begin
            for (i = 0; i < 8; i = i + 1) begin
                if (i < n)
                    bytes[i*8 +: 8] = item[(n-1-i)*8 +: 8];
            end
        end
    end
endmodule

// [csd_emcy.v]
// Builder of 8-byte emergency messages for local bus and I/O errors.
`timescale 1ns/1ps
`include "csd_regs.vh"
module csd_emcy (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Local bus error event.
    input wire bus_evt,
    input wire [15:0] bus_slot,
    input wire [15:0] bus_code,
    // Module I/O error event.
    input wire io_evt,
    input wire [15:0] io_code,
    input wire [15:0] io_slot,
    input wire [7:0] io_loc,
    input wire [7:0] io_prio,
    // Message out, byte 0 in bits 7:0.
    output reg emcy_valid,
    output reg [63:0] emcy_msg
);
    reg io_pend;
    reg [55:0] io_hold;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emcy_valid <= 1'b0;
            emcy_msg <= 64'h0000_0000_0000_0000;
            io_pend <= 1'b0;
            io_hold <= 56'h00_0000_0000_0000;
        end else begin
            emcy_valid <= 1'b0;
            // A bus error wins the cycle; a coincident I/O error waits for the first cycle without one.
            if (bus_evt) begin
                emcy_valid <= 1'b1;
                emcy_msg <= {8'h00, bus_code, bus_slot,
                    `CSD_EMCY_ERR_REG, `CSD_EMCY_BUS_CODE};
            end else if (io_pend) begin
                emcy_valid <= 1'b1;
                emcy_msg <= {8'h00, io_hold[55:24],
                    `CSD_EMCY_ERR_REG, io_hold[15:0]};
            end else if (io_evt) begin
                emcy_valid <= 1'b1;
                emcy_msg <= {8'h00, io_prio, io_loc, io_slot,
                    `CSD_EMCY_ERR_REG, io_code};
            end
            if (bus_evt && io_evt) begin
                io_pend <= 1'b1;
                io_hold <= {io_prio, io_loc, io_slot, 8'h00, io_code};
            end else if (!bus_evt) begin
                io_pend <= 1'b0;
            end
        end
    end
endmodule

// [csd_framer_monitor.sv]
// Checker of the status framer ports, bound to the framer.
`timescale 1ns/1ps
module csd_framer_monitor (
    // Clock, reset and bus.
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire pready,
    // Status events and results.
    input wire [6:0] al_err_evt,
    input wire al_err,
    input wire [15:0] al_code,
    input wire nv_we,
    // Image stream.
    input wire mod_ready,
    input wire pi_valid,
    input wire [7:0] pi_data,
    input wire pi_first,
    input wire pi_last,
    // Emergency.
    input wire lbus_err_evt,
    input wire io_err_evt,
    input wire [15:0] io_err_code,
    input wire emcy_valid,
    input wire [63:0] emcy_msg
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_evt;
        |al_err_evt |=> al_err;
    endproperty
    a_evt: assert property (p_evt) else $error("no al err");
    property p_wdog;
        al_err_evt[3] |=> al_code == 16'h001B;
    endproperty
    a_wdog: assert property (p_wdog) else $error("bad code");
    property p_stat;
        pi_first |-> pi_valid [*8];
    endproperty
    a_stat: assert property (p_stat) else $error("short block");
    property p_lead;
        pi_first |-> (!mod_ready && !pi_last) [*7];
    endproperty
    a_lead: assert property (p_lead) else $error("data early");
    property p_zero;
        pi_first |-> pi_data[7:1] == 7'h00 ##1 pi_data == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("bits set");
    property p_bus;
        lbus_err_evt |=> emcy_valid && emcy_msg[23:0] == 24'h80_1000
            && emcy_msg[63:56] == 8'h00;
    endproperty
    a_bus: assert property (p_bus) else $error("bus msg");
    property p_io;
        io_err_evt && !lbus_err_evt
            && !($past(lbus_err_evt) && $past(io_err_evt))
            |=> emcy_valid && emcy_msg[15:0] == $past(io_err_code)
            && emcy_msg[23:16] == 8'h80;
    endproperty
    a_io: assert property (p_io) else $error("io msg");
    property p_nv;
        psel && !penable && pwrite && paddr == 8'h00 |-> ##[1:2] nv_we;
    endproperty
    a_nv: assert property (p_nv) else $error("no store");
    c_frame: cover property (pi_last);
    c_emcy: cover property (emcy_valid);
    c_nv: cover property (nv_we);
endmodule
bind csd_framer csd_framer_monitor csd_framer_monitor_inst (.*);

// [csd_master_model.sv]
// Fieldbus master model gathering the input image byte stream.
`timescale 1ns/1ps
module csd_master_model (
    // Clock and image stream.
    input wire pclk,
    input wire pi_valid,
    input wire [7:0] pi_data,
    input wire pi_first,
    input wire pi_last,
    // Frame complete.
    output reg frame_done
);
    logic [7:0] got_q[$];
    initial frame_done = 1'b0;
    // The image restarts at the status block; module data follow it.
    always @(posedge pclk) begin
        if (pi_valid && pi_first) begin
            got_q = '{pi_data};
        end else if (pi_valid) begin
            got_q.push_back(pi_data);
        end
        frame_done <= pi_valid && pi_last;
    end
endmodule

// [test_coupler_status_diag_framer.sv]
// Self-checking bench of the status framer.
`timescale 1ns/1ps
`include "csd_regs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
$display("BAD %s exp %h got %h", n, e, g); end end
module test_coupler_status_diag_framer;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, io_err_loc = 0, io_err_prio = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, al_err, nv_we, mod_ready, e, frame_done;
    logic new_diag_msg = 0, cyc_start = 0, mod_valid = 0, mod_last = 0;
    logic [15:0] lbus_diag_status = 0, mod_err_code = 0, mod_err_pos = 0;
    logic [15:0] lbus_err_slot = 0, lbus_err_code = 0, al_code;
    logic [15:0] io_err_code = 0, io_err_slot = 0, dv[3];
    logic [6:0] al_err_evt = 0;
    logic [2:0] nv_swap = 3'h7, nv_wdata;
    logic nv_swap_valid = 0, lbus_err_evt = 0, io_err_evt = 0;
    logic [63:0] mod_data = 0, emcy_msg, v;
    logic [1:0] mod_width = 0;
    logic pi_valid, pi_first, pi_last, emcy_valid;
    logic [7:0] pi_data, exp_q[$];
    logic [15:0] codes[7] = '{`CSD_AL_BAD_CHANGE, `CSD_AL_NO_STATE,
        `CSD_AL_MBX_CFG, `CSD_AL_WDOG, `CSD_AL_OUT_CFG, `CSD_AL_IN_CFG,
        `CSD_AL_SYNC};
    integer seed = 32'h153000a1;
    int fails = 0, num_checks = 0, i, k;
    csd_framer csd_framer_inst (.*);
    csd_master_model csd_master_model_inst (.*);
    always #2.5 pclk = ~pclk;
    task automatic apb(input w, input [7:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frame(input [2:0] sw);
        int w, nb;
        logic le;
        logic [7:0] got[$];
        apb(1, `CSD_ADDR_CTRL, {29'h0, sw});
        `CHK("nv_we", 1'b1, nv_we)
        @(posedge pclk);
        `CHK("nv_wdata", sw, nv_wdata)
        v = {$random(seed), $random(seed)};
        dv = '{v[15:0], v[31:16], v[47:32]};
        new_diag_msg <= v[48];
        lbus_diag_status <= dv[0];
        mod_err_code <= dv[1];
        mod_err_pos <= dv[2];
        cyc_start <= 1'b1;
        @(posedge pclk);
        cyc_start <= 1'b0;
        exp_q = '{{7'h0, v[48]}, 8'h0, dv[0][7:0], dv[0][15:8],
            dv[1][7:0], dv[1][15:8], dv[2][7:0], dv[2][15:8]};
        for (w = 0; w < 4; w++) begin
            nb = 1 << w;
            v = {$random(seed), $random(seed)};
            v = v & ((64'h1 << (8 * nb)) - 64'h1);
            le = (w == 0) || sw[w - 1];
            for (k = 0; k < nb; k++)
                exp_q.push_back(le ? v[8*k+:8] : v[8*(nb-1-k)+:8]);
            mod_valid <= 1'b1;
            mod_data <= v;
            mod_width <= w[1:0];
            mod_last <= (w == 3);
            do @(posedge pclk); while (!mod_ready);
        end
        mod_valid <= 1'b0;
        mod_last <= 1'b0;
        do @(posedge pclk); while (!frame_done);
        got = csd_master_model_inst.got_q;
        `CHK("pi_len", exp_q.size(), got.size())
        for (k = 0; k < exp_q.size(); k++)
            `CHK("pi_byte", exp_q[k], got[k])
        for (k = 0; k < 3; k++) begin
            apb(0, `CSD_ADDR_DIAG_BUS + 8'(4 * k), 0);
            `CHK("diag", {16'h0, dv[k]}, r)
        end
        apb(0, `CSD_ADDR_STAT0, 0);
        `CHK("word0", {31'h0, new_diag_msg}, r)
    endtask
    task automatic emcy(input b);
        v = {$random(seed), $random(seed)};
        {lbus_err_slot, lbus_err_code, io_err_code, io_err_slot} <= v;
        {io_err_loc, io_err_prio} <= v[15:0];
        lbus_err_evt <= b;
        io_err_evt <= 1'b1;
        @(posedge pclk);
        lbus_err_evt <= 1'b0;
        io_err_evt <= 1'b0;
        if (b) begin
            #1 `CHK("bus_msg", {8'h0, lbus_err_code, lbus_err_slot,
                8'h80, 16'h1000}, emcy_valid ? emcy_msg : 64'h0)
            @(posedge pclk);
        end
        #1 `CHK("io_msg", {8'h0, io_err_prio, io_err_loc, io_err_slot,
            8'h80, io_err_code}, emcy_valid ? emcy_msg : 64'h0)
        @(posedge pclk);
    endtask
    task automatic conclude;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(0, `CSD_ADDR_CTRL, 0);
        `CHK("ctrl", 32'h0000_0007, r)
        nv_swap <= 3'h2;
        nv_swap_valid <= 1'b1;
        apb(0, `CSD_ADDR_CTRL, 0);
        `CHK("nv_load", 32'h0000_0002, r)
        for (i = 0; i < 7; i++) begin
            al_err_evt <= 7'(1 << i);
            @(posedge pclk);
            al_err_evt <= 7'h00;
            apb(0, `CSD_ADDR_AL_CODE, 0);
            `CHK("al_code", {16'h0, codes[i]}, r)
            `CHK("al_err", 1'b1, al_err)
            apb(1, `CSD_ADDR_AL_STAT, 32'h0000_0010);
            `CHK("al_err_clr", 1'b0, al_err)
            apb(0, `CSD_ADDR_AL_CODE, 0);
            `CHK("al_clr", 32'h0000_0000, r)
        end
        frame(3'h7);
        frame(3'h0);
        frame(3'($random(seed)));
        emcy(1'b1);
        emcy(1'b0);
        apb(0, 8'h40, 0);
        `CHK("slverr", 1'b1, e)
        conclude();
    end
endmodule
